// file: src/profile_position_start_control.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "ppstart_defs.svh"

// Functional notes
// - Bit6 low: target is absolute
// - Bit6 high: target is travel amount
// - Buffered: store new command, run after completion
// - Immediate: new command replaces running one
// - Start on bit4 rising edge
// - Start too soon after halt ignored
// - Reject start on halt, stop, not enabled
module profile_position_start_control
(
  // Clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RESET,
  // Register port
  input  wire logic [15:0]        ADDR,
  input  wire logic [15:0]        WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [15:0]        RDATA,
  // Drive context
  input  wire logic               COMM_TICK,
  input  wire logic               STOP_IN,
  input  wire logic               OP_ENABLED,
  input  wire logic [31:0]        TARGET_POS,
  input  wire logic               MOTION_DONE,
  // Command to motion engine
  output logic                    START,
  output logic                    REPLACE,
  output ppstart_pkg::cmd_s       CMD,
  output logic                    BUSY,
  output logic                    SETPOINT_ACK
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [15:0]        cw_r;
  logic               start_prev_r;
  logic               settled;
  logic               start_edge;
  logic               accept;
  ppstart_pkg::run_e  run_r;
  ppstart_pkg::cmd_s  pend_cmd_r;
  logic               pend_r;
  logic               reject_r;
  logic               start_r;
  logic               replace_r;
  ppstart_pkg::cmd_s  cmd_r;
  logic               ack_r;
  logic [15:0]        rdata_r;
  logic [15:0]        rdata_nxt;

  // Build a command from control word and target value
  function automatic ppstart_pkg::cmd_s make_cmd
  (
    input logic [15:0] cw,
    input logic [31:0] target
  );
    ppstart_pkg::cmd_s c;
    c.wrap     = cw[`CW_WRAP_BIT];
    c.push     = cw[`CW_PUSH_BIT];
    c.origin   = cw[`CW_ORIGIN_BIT];
    c.relative = cw[`CW_REL_BIT];
    c.target   = target;
    return c;
  endfunction : make_cmd

  // --------------------------------------------------------------------
  // Control word register
  // --------------------------------------------------------------------

  // Written by the master once per communication cycle
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      cw_r <= `CW_RESET;
    else if (WR && (ADDR == `CW_ADDR))
      cw_r <= WDATA;
  end

  // --------------------------------------------------------------------
  // Start request qualification
  // --------------------------------------------------------------------

  // Previous start bit for edge detection
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      start_prev_r <= 1'b0;
    else
      start_prev_r <= cw_r[`CW_START_BIT];
  end

  // Halt release needs settling time before a start counts
  halt_settle u_settle
  (
    .clk       (CLOCK),
    .rst       (RESET),
    .halt      (cw_r[`CW_HALT_BIT]),
    .comm_tick (COMM_TICK),
    .settled   (settled)
  );

  // Only a 0-to-1 change starts; a held level does nothing
  assign start_edge = cw_r[`CW_START_BIT] && !start_prev_r;

  // Settled also implies halt is low
  assign accept = start_edge && settled && !STOP_IN
                  && OP_ENABLED;

  // Record rejected edges for software visibility
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      reject_r <= 1'b0;
    else if (start_edge)
      reject_r <= !accept;
  end

  // --------------------------------------------------------------------
  // Run state and buffered command
  // --------------------------------------------------------------------

  // Idle until started, moving until done with nothing pending or operation enabled lost
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      run_r <= ppstart_pkg::ST_IDLE;
    else
    begin
      unique case (run_r)
        ppstart_pkg::ST_IDLE:
        begin
          if (accept)
            run_r <= ppstart_pkg::ST_MOVING;
        end
        ppstart_pkg::ST_MOVING:
        begin
          if (!OP_ENABLED)
            run_r <= ppstart_pkg::ST_IDLE;
          else if (MOTION_DONE && !pend_r && !accept)
            run_r <= ppstart_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Buffered mode keeps one command waiting; a newer one overwrites it
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      pend_r     <= 1'b0;
      pend_cmd_r <= '0;
    end
    else if (!OP_ENABLED)
      pend_r <= 1'b0;
    else if (accept && (run_r == ppstart_pkg::ST_MOVING)
             && !cw_r[`CW_IMMED_BIT] && !(MOTION_DONE && !pend_r))
    begin
      pend_r     <= 1'b1;
      pend_cmd_r <= make_cmd(cw_r, TARGET_POS);
    end
    else if (MOTION_DONE && (run_r == ppstart_pkg::ST_MOVING))
      pend_r <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Command outputs
  // --------------------------------------------------------------------

  // Start pulse: fresh start, immediate replace, or queued one on done
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      start_r   <= 1'b0;
      replace_r <= 1'b0;
      cmd_r     <= '0;
    end
    else
    begin
      start_r   <= 1'b0;
      replace_r <= 1'b0;
      if (accept && (run_r == ppstart_pkg::ST_IDLE))
      begin
        start_r <= 1'b1;
        cmd_r   <= make_cmd(cw_r, TARGET_POS);
      end
      else if (accept && cw_r[`CW_IMMED_BIT])
      begin
        start_r   <= 1'b1;
        replace_r <= 1'b1;
        cmd_r     <= make_cmd(cw_r, TARGET_POS);
      end
      // Empty queue and the move ends now: storing would strand it
      else if (accept && MOTION_DONE && !pend_r)
      begin
        start_r <= 1'b1;
        cmd_r   <= make_cmd(cw_r, TARGET_POS);
      end
      else if (MOTION_DONE && pend_r && OP_ENABLED
               && (run_r == ppstart_pkg::ST_MOVING))
      begin
        start_r <= 1'b1;
        cmd_r   <= pend_cmd_r;
      end
    end
  end

  // Acknowledge follows start bit and drops outside operation enabled
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      ack_r <= 1'b0;
    else if (!cw_r[`CW_START_BIT] || !OP_ENABLED)
      ack_r <= 1'b0;
    else if (accept)
      ack_r <= 1'b1;
  end

  // --------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------

  // Unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (ADDR == `CW_ADDR)
      rdata_nxt = cw_r;
    else if (ADDR == `STAT_ADDR)
    begin
      rdata_nxt[`ST_READY_BIT]  = settled;
      rdata_nxt[`ST_ACK_BIT]    = ack_r;
      rdata_nxt[`ST_BUSY_BIT]   = (run_r == ppstart_pkg::ST_MOVING);
      rdata_nxt[`ST_PEND_BIT]   = pend_r;
      rdata_nxt[`ST_REJECT_BIT] = reject_r;
    end
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      rdata_r <= 16'h0000;
    else if (RD)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 16'h0000;
  end

  // --------------------------------------------------------------------
  // Output drive
  // --------------------------------------------------------------------
  assign RDATA        = rdata_r;
  assign START        = start_r;
  assign REPLACE      = replace_r;
  assign CMD          = cmd_r;
  assign BUSY         = (run_r == ppstart_pkg::ST_MOVING);
  assign SETPOINT_ACK = ack_r;

endmodule : profile_position_start_control

// file: src/ppstart_defs.svh
`ifndef PPSTART_DEFS_SVH
`define PPSTART_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CW_ADDR          16'h6040
`define STAT_ADDR        16'h6044
`define CW_RESET         16'h0000

// ----------------------------------------------------------------------
// Control word bit positions
// ----------------------------------------------------------------------
`define CW_START_BIT     4
`define CW_IMMED_BIT     5
`define CW_REL_BIT       6
`define CW_HALT_BIT      8
`define CW_ORIGIN_BIT    12
`define CW_PUSH_BIT      13
`define CW_WRAP_BIT      14

// ----------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------
`define ST_READY_BIT     0
`define ST_ACK_BIT       1
`define ST_BUSY_BIT      2
`define ST_PEND_BIT      3
`define ST_REJECT_BIT    4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HALT_SETTLE_CYC  2'd2

`endif

// file: src/ppstart_pkg.sv
package ppstart_pkg;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_MOVING} run_e;

  // One positioning command as handed to the motion engine
  typedef struct packed {
    logic        wrap;
    logic        push;
    logic        origin;
    logic        relative;
    logic [31:0] target;
  } cmd_s;

endpackage : ppstart_pkg

// file: src/halt_settle.sv
`timescale 1ns/10ps
`include "ppstart_defs.svh"

// Counts communication cycles since halt was released
module halt_settle
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic halt,
  input  wire logic comm_tick,
  // Result
  output logic      settled
);

  logic [1:0] count_r;

  // Restart the count on halt, saturate once settled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_r <= `HALT_SETTLE_CYC;
    else if (halt)
      count_r <= 2'd0;
    else if (comm_tick && (count_r != `HALT_SETTLE_CYC))
      count_r <= count_r + 2'd1;
  end

  assign settled = !halt && (count_r == `HALT_SETTLE_CYC);

endmodule : halt_settle

// file: verification/ppstart_checker.sv
`timescale 1ns/10ps
`include "ppstart_defs.svh"
module ppstart_checker
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET,
  // Bus and drive context
  input wire logic        WR,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        COMM_TICK,
  input wire logic        STOP_IN,
  input wire logic        OP_ENABLED,
  input wire logic        MOTION_DONE,
  // Command outputs
  input wire logic        START,
  input wire logic        REPLACE,
  input wire logic        BUSY
);
  logic [15:0] cw_r;
  logic [1:0]  tk_r;
  logic        ok;

  // Shadow of the control word
  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
      cw_r <= `CW_RESET;
    else if (WR && ADDR == `CW_ADDR)
      cw_r <= WDATA;

  // Ticks since halt release; saturates at 3 to leave a margin
  always_ff @(posedge CLOCK or posedge RESET)
    if (RESET)
      tk_r <= 2'h3;
    else if (cw_r[8])
      tk_r <= 2'h0;
    else if (COMM_TICK && tk_r != 2'h3)
      tk_r <= tk_r + 2'h1;

  // Every start condition met
  assign ok = !cw_r[8] && tk_r == 2'h3 && !STOP_IN && OP_ENABLED;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  // Bit4 written 0 to 1, then the judging cycle
  sequence s_rise;
    WR && ADDR == `CW_ADDR && WDATA[4] && !cw_r[4];
  endsequence
  sequence s_busy_go;
    s_rise ##1 ok && BUSY && !MOTION_DONE;
  endsequence

  a_start_idle: assert property (s_rise ##1 ok && !BUSY |=> START)
    else $error("start missing");
  a_start_replace: assert property
    (s_busy_go ##0 cw_r[5] |=> START && REPLACE)
    else $error("replace missing");
  a_buffer_hold: assert property
    (s_busy_go ##0 !cw_r[5] |=> !START)
    else $error("buffered start ran early");
  a_halt_reject: assert property
    (s_rise ##1 (cw_r[8] || STOP_IN || !OP_ENABLED) && !BUSY |=> !START)
    else $error("refused start ran");
  a_settle_wait: assert property
    (s_rise ##1 !cw_r[8] && tk_r < 2'h2 && !BUSY |=> !START)
    else $error("start before settling");
  a_hold_once: assert property
    (WR && ADDR == `CW_ADDR && cw_r[4] && !BUSY |=> ##1 !START)
    else $error("held bit restarted");
  a_start_busy: assert property (START |-> BUSY)
    else $error("start without busy");
  a_replace_pair: assert property (REPLACE |-> START)
    else $error("replace alone");
endmodule : ppstart_checker

bind profile_position_start_control ppstart_checker u_ppstart_checker
(
  .CLOCK(CLOCK), .RESET(RESET), .WR(WR), .ADDR(ADDR), .WDATA(WDATA),
  .COMM_TICK(COMM_TICK), .STOP_IN(STOP_IN), .OP_ENABLED(OP_ENABLED),
  .MOTION_DONE(MOTION_DONE), .START(START), .REPLACE(REPLACE),
  .BUSY(BUSY)
);

// file: verification/fieldbus_master_model.sv
`timescale 1ns/10ps
`include "ppstart_defs.svh"
module fieldbus_master_model
#(
  parameter int TICK_CYC = 8
)
(
  // Clock
  input  wire logic        clk,
  // Register port and cycle tick
  output logic [15:0]      addr = 16'h0000,
  output logic [15:0]      wdata = 16'h0000,
  output logic             wr = 1'b0,
  output logic             rd = 1'b0,
  input  wire logic [15:0] rdata,
  output logic             tick = 1'b0
);
  int cnt_r = 0;

  // One tick per communication cycle
  always @(posedge clk)
  begin
    cnt_r <= (cnt_r + 1) % TICK_CYC;
    tick  <= cnt_r == TICK_CYC - 1;
  end

  // Released wdata shows the inverse, never a stale value; addr keeps CW_ADDR
  task put(input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= `CW_ADDR;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask : put

  // Mode bits settle with bit4 low before it rises
  task send(input logic [15:0] cw);
    put(cw & 16'hFFEF);
    put(cw | 16'h0010);
  endtask : send

  // Halt cleared, then over two cycles of wait
  task settle;
    put(16'h0000);
    repeat (3) @(posedge tick);
  endtask : settle

  task get(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask : get
endmodule : fieldbus_master_model

// file: verification/test_profile_position_start_control.sv
`timescale 1ns/10ps
`include "ppstart_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  error_cnt++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
  $time, (a), (e)); end end
module test_profile_position_start_control;
  logic CLOCK = 1'b0, RESET = 1'b1, STOP_IN = 1'b0, OP_ENABLED = 1'b1;
  logic MOTION_DONE = 1'b0, WR, RD, COMM_TICK, START, REPLACE, BUSY;
  logic SETPOINT_ACK;
  logic [15:0] ADDR, WDATA, RDATA, rd_v, cw;
  logic [31:0] TARGET_POS = 32'h0, lfsr = 32'hD17F;
  ppstart_pkg::cmd_s CMD, got;
  logic rep;
  int error_cnt = 0, comparisons = 0, starts = 0, n;

  always #25 CLOCK = ~CLOCK;

  profile_position_start_control u_profile_position_start_control
  (
    .CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .COMM_TICK(COMM_TICK), .STOP_IN(STOP_IN),
    .OP_ENABLED(OP_ENABLED), .TARGET_POS(TARGET_POS), .BUSY(BUSY),
    .MOTION_DONE(MOTION_DONE), .START(START), .REPLACE(REPLACE),
    .CMD(CMD), .SETPOINT_ACK(SETPOINT_ACK)
  );
  fieldbus_master_model u_fieldbus_master_model
  (
    .clk(CLOCK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD),
    .rdata(RDATA), .tick(COMM_TICK)
  );

  function automatic logic [31:0] step(input logic [31:0] v);
    step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : step
  function automatic ppstart_pkg::cmd_s want(input logic [15:0] c,
                                             input logic [31:0] t);
    want = {c[14:12], c[6], t};
  endfunction : want

  // Tally start pulses and keep what they carried
  always @(posedge CLOCK)
    if (START === 1'b1)
    begin
      starts++;
      got = CMD;
      rep = REPLACE;
    end

  task wt(input int c);
    repeat (c) @(posedge CLOCK);
    #1;
  endtask : wt
  task go(input logic [15:0] c);
    lfsr = step(lfsr);
    TARGET_POS <= lfsr;
    n = starts;
    u_fieldbus_master_model.send(c);
    wt(3);
  endtask : go
  task done;
    @(posedge CLOCK);
    MOTION_DONE <= 1'b1;
    @(posedge CLOCK);
    MOTION_DONE <= 1'b0;
    wt(2);
  endtask : done
  task final_report;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    wt(8);
    RESET <= 1'b0;
    u_fieldbus_master_model.get(`CW_ADDR, rd_v);
    `CHK(rd_v, `CW_RESET);
    u_fieldbus_master_model.get(16'h1234, rd_v);
    `CHK(rd_v, 16'h0000);
    $display("registers done");
    for (int m = 0; m < 16; m++)
    begin
      cw = {1'b0, m[3:1], 5'h00, m[0], 6'h00};
      go(cw);
      `CHK(starts, n + 1);
      `CHK(got, want(cw, lfsr));
      `CHK(SETPOINT_ACK, 1'b1);
      u_fieldbus_master_model.put(cw | 16'h0010);
      wt(3);
      `CHK(starts, n + 1);
      done();
      `CHK(BUSY, 1'b0);
      u_fieldbus_master_model.put(cw | 16'h0010);
      wt(3);
      `CHK(starts, n + 1);
    end
    $display("modes done");
    for (int k = 0; k < 3; k++)
    begin
      STOP_IN <= k == 0;
      OP_ENABLED <= k != 1;
      go(k == 2 ? 16'h0100 : 16'h0000);
      `CHK(starts, n);
      `CHK(SETPOINT_ACK, 1'b0);
    end
    u_fieldbus_master_model.get(`STAT_ADDR, rd_v);
    `CHK(rd_v, 16'h0001 << `ST_REJECT_BIT);
    STOP_IN <= 1'b0;
    OP_ENABLED <= 1'b1;
    go(16'h0000);
    `CHK(starts, n);
    u_fieldbus_master_model.settle();
    go(16'h0020);
    `CHK(starts, n + 1);
    $display("refusals done");
    go(16'h0020);
    `CHK(rep, 1'b1);
    `CHK(got, want(16'h0020, lfsr));
    go(16'h1000);
    `CHK(starts, n);
    u_fieldbus_master_model.get(`STAT_ADDR, rd_v);
    `CHK(rd_v, 16'h000F);
    done();
    `CHK(starts, n + 1);
    `CHK(got, want(16'h1000, lfsr));
    `CHK(BUSY, 1'b1);
    done();
    `CHK(BUSY, 1'b0);
    $display("update modes done");
    final_report();
  end

  // Run needs well under 1000 cycles
  initial
  begin
    wt(6000);
    error_cnt++;
    final_report();
  end
endmodule : test_profile_position_start_control
